// *** core/adcsq_pkg.sv ***
// package: register map, field positions and timing counts of the converter control
package adcsq_pkg;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_SELECT = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_RES_LOW = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_RES_HIGH = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_SLEEP = 12'h010;
	// selection register fields
	localparam int SEL_REF_HI = 7;
	localparam int SEL_REF_LO = 6;
	localparam int SEL_LEFT = 5;
	localparam int SEL_ZERO = 4;
	localparam int SEL_CH_HI = 3;
	localparam int SEL_CH_LO = 0;
	// control/status fields
	localparam int CS_EN = 7;
	localparam int CS_START = 6;
	localparam int CS_FREE = 5;
	localparam int CS_DONE = 4;
	localparam int CS_IRQ_EN = 3;
	localparam int CS_DIV_HI = 2;
	localparam int CS_DIV_LO = 0;
	// sleep control register fields
	localparam int SL_MODE_HI = 2;
	localparam int SL_MODE_LO = 0;
	localparam logic [7:0] SELECT_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] SLEEP_RST = 8'h00;
	// conversion lengths in converter clock cycles
	localparam logic [4:0] CONV_NORMAL = 5'h0D;
	localparam logic [4:0] CONV_FIRST = 5'h19;
	localparam logic [9:0] CODE_MAX = 10'h3FF;
	typedef enum logic [1:0] {
		ADCSQ_REF_EXT,
		ADCSQ_REF_SUPPLY,
		ADCSQ_REF_RSVD,
		ADCSQ_REF_INT256
	} adcsq_ref_e;
	typedef enum logic [2:0] {
		ADCSQ_SLP_ACTIVE,
		ADCSQ_SLP_IDLE,
		ADCSQ_SLP_NOISE,
		ADCSQ_SLP_PDOWN,
		ADCSQ_SLP_PSAVE,
		ADCSQ_SLP_STBY
	} adcsq_sleep_e;
endpackage : adcsq_pkg

// *** core/adcsq_prescaler.sv ***
// prescaler: one-cycle converter clock enable from the system clock
module adcsq_prescaler (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// control
	input wire logic run_i,
	input wire logic [2:0] div_sel_i,
	// tick
	output logic tick_o
);
	import adcsq_pkg::*;

	logic [6:0] cnt_reg;
	logic tick_reg;
	logic [6:0] last;

	// 000 and 001 both divide by two
	function automatic logic [6:0] div_last(input logic [2:0] s);
		logic [6:0] r;
		r = 7'h01;
		if (s > 3'h1) begin
			r = 7'((8'h01 << s) - 8'h01);
		end
		return r;
	endfunction

	assign last = div_last(div_sel_i); // R18
	assign tick_o = tick_reg;

	// held in reset while the converter is off
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= 7'h00;
			tick_reg <= 1'b0;
		end else if (!run_i) begin
			cnt_reg <= 7'h00;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (cnt_reg >= last);
			cnt_reg <= (cnt_reg >= last) ? 7'h00 : cnt_reg + 7'h01;
		end
	end
endmodule // adcsq_prescaler

// *** core/adcsq_ctrl.sv ***
// converter sequencer control: apb registers, sequencing and sleep start
// Behaviour
// R01: software prepares converter enabled, idle, single mode, irq enabled before sleep.
// R02: sleep in idle or noise mode with converter prepared starts a conversion.
// R03: completion raises wake request when nothing else woke the core.
// R04: completion request still raised after another interrupt woke the core.
// R05: after wake the core stays active until a new sleep command.
// R06: other sleep states leave the converter enable untouched.
// R07: software should clear enable before deep sleep to save power.
// R08: result bytes readable once the done flag is set.
// R09: result is a 10-bit code from 0x000 to 0x3FF.
// R10: reference and channel changes apply only after the conversion completes.
// R11: reference code decodes to external, supply, reserved, internal 2.56V.
// R12: software must not select internal references with external reference driven.
// R13: left-justify bit changes result presentation immediately.
// R14: channel code selects pins 0-7, bandgap, ground or nothing.
// R15: control/status holds enable, start, free-run, done, irq enable, divider.
// R16: writing one to start begins conversion; reads one while running.
// R17: done flag sets at completion; cleared by vector ack or writing one.
// R18: divider select gives 2,2,4,8,16,32,64,128.
// R19: normal conversion 13 converter clocks, first after enable 25.
// R20: selection register bit 4 reads zero and ignores writes.
//
// Design decisions made here: the APB register port and the register offsets.
module adcsq_ctrl (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [adcsq_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// processor sleep interface
	input wire logic core_halted_i,
	input wire logic other_wake_i,
	input wire logic irq_ack_i,
	output logic irq_req_o,
	output logic wake_o,
	// analog core
	input wire logic [9:0] analog_code_i,
	output logic [1:0] ref_sel_o,
	output logic ext_ref_only_o,
	output logic [3:0] channel_sel_o,
	output logic channel_valid_o,
	output logic analog_on_o,
	output logic sample_o
);
	import adcsq_pkg::*;

	typedef enum logic [1:0] {
		ADCSQ_IDLE,
		ADCSQ_WAIT_EDGE,
		ADCSQ_CONVERT
	} adcsq_state_e;

	adcsq_state_e state_reg;
	logic [7:0] sel_reg;
	logic [7:0] ctrl_reg;
	logic [2:0] sleep_reg;
	logic [1:0] ref_act_reg;
	logic [3:0] ch_act_reg;
	logic [9:0] result_reg;
	logic [4:0] cyc_reg;
	logic [4:0] len_reg;
	logic first_reg;
	logic sleep_armed_reg;
	logic sleep_started_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic irq_req_reg;
	logic wake_reg;
	logic sample_reg;
	logic ext_ref_reg;
	logic ch_valid_reg;

	logic tick;
	logic access;
	logic wr;
	logic hit_sel;
	logic hit_ctrl;
	logic hit_low;
	logic hit_high;
	logic hit_sleep;
	logic hit_any;
	logic en;
	logic free_run;
	logic busy;
	logic finish;
	logic start_wr;
	logic done_clr_wr;
	logic en_rise;
	logic sleep_trig;
	logic conv_go;
	logic [15:0] result_view;
	logic [7:0] ctrl_view;
	logic [31:0] rdata;
	logic ext_ref_next;
	logic ch_valid_next;

	adcsq_prescaler u_presc (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.run_i(ctrl_reg[CS_EN]),
		.div_sel_i(ctrl_reg[CS_DIV_HI:CS_DIV_LO]),
		.tick_o(tick)
	);

	// apb decode: one wait state, answer on the second access cycle
	assign access = psel_i && penable_i && !pready_reg;
	assign wr = access && pwrite_i;
	assign hit_sel = (paddr_i == OFS_SELECT);
	assign hit_ctrl = (paddr_i == OFS_CTRL);
	assign hit_low = (paddr_i == OFS_RES_LOW);
	assign hit_high = (paddr_i == OFS_RES_HIGH);
	assign hit_sleep = (paddr_i == OFS_SLEEP);
	assign hit_any = hit_sel || hit_ctrl || hit_low || hit_high || hit_sleep;

	assign en = ctrl_reg[CS_EN];
	assign free_run = ctrl_reg[CS_FREE];
	assign busy = (state_reg != ADCSQ_IDLE);
	assign finish = (state_reg == ADCSQ_CONVERT) && tick && (cyc_reg == len_reg);
	assign start_wr = wr && hit_ctrl && pwdata_i[CS_START] && pwdata_i[CS_EN];
	assign done_clr_wr = wr && hit_ctrl && pwdata_i[CS_DONE];
	assign en_rise = wr && hit_ctrl && pwdata_i[CS_EN] && !en;
	// noise-reduction or idle sleep, prepared, core halted
	assign sleep_trig = sleep_armed_reg && core_halted_i && en && !busy
		&& !free_run && ctrl_reg[CS_IRQ_EN]; // R02 R01
	assign conv_go = start_wr || sleep_trig;

	// presentation follows the left-justify bit at once, even mid-conversion
	assign result_view = sel_reg[SEL_LEFT] ? {result_reg, 6'h00}
		: {6'h00, result_reg}; // R13
	assign ctrl_view = {ctrl_reg[7], busy, ctrl_reg[5:0]}; // R16
	// flags decoded ahead so the pins come straight from flip-flops
	assign ext_ref_next = (sel_reg[SEL_REF_HI:SEL_REF_LO] == ADCSQ_REF_EXT); // R11
	assign ch_valid_next = !sel_reg[SEL_CH_HI]
		|| (sel_reg[SEL_CH_HI-1:SEL_CH_LO+1] == 2'h3); // R14

	always_comb begin
		rdata = 32'h0000_0000;
		if (hit_sel) begin
			rdata[7:0] = sel_reg;
		end else if (hit_ctrl) begin
			rdata[7:0] = ctrl_view; // R15
		end else if (hit_low) begin
			rdata[7:0] = result_view[7:0]; // R08
		end else if (hit_high) begin
			rdata[7:0] = result_view[15:8]; // R08
		end else if (hit_sleep) begin
			rdata[2:0] = sleep_reg;
		end
	end

	// apb answer registers
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= access;
			pslverr_reg <= access && !hit_any;
			if (access && !pwrite_i) begin
				prdata_reg <= rdata;
			end
		end
	end

	// selection register; bit 4 stays zero
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sel_reg <= SELECT_RST;
		end else if (wr && hit_sel) begin
			sel_reg <= pwdata_i[7:0] & ~(8'h01 << SEL_ZERO); // R20
		end
	end

	// settings in use track the register only while no conversion holds them
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ref_act_reg <= 2'h0;
			ch_act_reg <= 4'h0;
			ext_ref_reg <= 1'b1;
			ch_valid_reg <= 1'b1;
		end else if (!busy || finish) begin
			ref_act_reg <= sel_reg[SEL_REF_HI:SEL_REF_LO]; // R10
			ch_act_reg <= sel_reg[SEL_CH_HI:SEL_CH_LO]; // R10
			ext_ref_reg <= ext_ref_next; // R11
			ch_valid_reg <= ch_valid_next; // R14
		end
	end

	// control/status; done flag set wins over any clear
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_reg <= CTRL_RST;
		end else begin
			if (wr && hit_ctrl) begin
				ctrl_reg[CS_EN] <= pwdata_i[CS_EN]; // R06
				ctrl_reg[CS_FREE] <= pwdata_i[CS_FREE];
				ctrl_reg[CS_IRQ_EN] <= pwdata_i[CS_IRQ_EN];
				ctrl_reg[CS_DIV_HI:CS_DIV_LO] <= pwdata_i[CS_DIV_HI:CS_DIV_LO];
			end
			ctrl_reg[CS_START] <= 1'b0;
			if (finish) begin
				ctrl_reg[CS_DONE] <= 1'b1; // R17
			end else if (done_clr_wr || irq_ack_i) begin
				ctrl_reg[CS_DONE] <= 1'b0; // R17
			end
		end
	end

	// sleep command register: written by the core on each sleep instruction
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sleep_reg <= SLEEP_RST[2:0];
			sleep_armed_reg <= 1'b0;
		end else if (wr && hit_sleep) begin
			sleep_reg <= pwdata_i[SL_MODE_HI:SL_MODE_LO];
			sleep_armed_reg <= (pwdata_i[2:0] == ADCSQ_SLP_IDLE)
				|| (pwdata_i[2:0] == ADCSQ_SLP_NOISE);
		end else if (sleep_trig || other_wake_i || wake_reg) begin
			// one sleep command starts at most one conversion
			sleep_armed_reg <= 1'b0; // R05
			sleep_reg <= ADCSQ_SLP_ACTIVE; // R05
		end
	end

	// conversion sequencer
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ADCSQ_IDLE;
			cyc_reg <= 5'h00;
			len_reg <= CONV_NORMAL;
			first_reg <= 1'b0;
			result_reg <= 10'h000;
			sample_reg <= 1'b0;
		end else begin
			sample_reg <= 1'b0;
			if (en_rise) begin
				first_reg <= 1'b1;
			end
			if (!en) begin
				state_reg <= ADCSQ_IDLE;
				if (conv_go) begin
					state_reg <= ADCSQ_WAIT_EDGE;
				end
			end else begin
				case (state_reg)
				ADCSQ_IDLE: begin
					if (conv_go) begin
						state_reg <= ADCSQ_WAIT_EDGE; // R16
					end
				end
				ADCSQ_WAIT_EDGE: begin
					if (tick) begin
						state_reg <= ADCSQ_CONVERT;
						cyc_reg <= 5'h01;
						len_reg <= first_reg ? CONV_FIRST : CONV_NORMAL; // R19
						first_reg <= 1'b0;
					end
				end
				ADCSQ_CONVERT: begin
					if (tick) begin
						cyc_reg <= cyc_reg + 5'h01;
						if (finish) begin
							result_reg <= analog_code_i & CODE_MAX; // R09
							sample_reg <= 1'b1;
							cyc_reg <= 5'h01;
							len_reg <= CONV_NORMAL;
							if (!free_run) begin
								state_reg <= ADCSQ_IDLE;
							end
						end
					end
				end
				default: begin
					state_reg <= ADCSQ_IDLE;
				end
				endcase
			end
		end
	end

	// wake request from a sleep-started conversion
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sleep_started_reg <= 1'b0;
			irq_req_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			if (sleep_trig) begin
				sleep_started_reg <= 1'b1;
			end else if (finish || !en) begin
				sleep_started_reg <= 1'b0;
			end
			// request raised whatever woke the core first
			irq_req_reg <= ctrl_reg[CS_IRQ_EN]
				&& (ctrl_reg[CS_DONE] || finish); // R04
			wake_reg <= finish && sleep_started_reg
				&& ctrl_reg[CS_IRQ_EN]; // R03
		end
	end

	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign irq_req_o = irq_req_reg;
	assign wake_o = wake_reg;
	assign ref_sel_o = ref_act_reg; // R11
	assign ext_ref_only_o = ext_ref_reg; // R11
	assign channel_sel_o = ch_act_reg; // R14
	assign channel_valid_o = ch_valid_reg; // R14
	assign analog_on_o = ctrl_reg[CS_EN];
	assign sample_o = sample_reg;
endmodule // adcsq_ctrl

// *** verification/adcsq_ctrl_asserts.sv ***
// checker: port-level relations of the converter sequencer control
module adcsq_ctrl_asserts (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// sleep and analog side
	input wire logic wake_o,
	input wire logic irq_req_o,
	input wire logic [1:0] ref_sel_o,
	input wire logic ext_ref_only_o,
	input wire logic [3:0] channel_sel_o,
	input wire logic channel_valid_o,
	input wire logic analog_on_o,
	input wire logic sample_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	ext_ref_a: assert property (ext_ref_only_o == (ref_sel_o == 2'h0))
		else $error("external reference flag wrong");
	chan_valid_a: assert property (channel_valid_o ==
		(channel_sel_o < 4'h8 || channel_sel_o > 4'hD))
		else $error("channel valid flag wrong");
	apb_answer_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("no ready after one wait state");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	err_zero_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
		else $error("refused read returned data");
	upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
		else $error("upper read bits not zero");
	wake_irq_a: assert property (wake_o |=> irq_req_o)
		else $error("wake without interrupt request");
	sample_gap_a: assert property (sample_o |=> !sample_o [*8])
		else $error("captures too close together");
	off_idle_a: assert property (!analog_on_o [*2] |-> !sample_o)
		else $error("capture while converter off");
endmodule // adcsq_ctrl_asserts

// *** verification/adcsq_analog_model.sv ***
// analog core model: code from reference and channel
module adcsq_analog_model (
	// clock
	input wire logic clk_i,
	// selection from the control
	input wire logic [1:0] ref_i,
	input wire logic [3:0] chan_i,
	input wire logic on_i,
	// result
	output logic [9:0] code_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] junk = 10'h155;
	// unpowered or unconnected input gives a changing pattern, not a held value
	always @(posedge clk_i) junk <= ~junk;
	assign code_o = (!on_i || (chan_i > 4'h7 && chan_i < 4'hE)) ? junk :
		(chan_i == 4'hF) ? 10'h000 : {ref_i, chan_i, 4'hA};
endmodule // adcsq_analog_model

// *** verification/adcsq_ctrl_tb_top.sv ***
// testbench top: apb tasks and scenarios for the converter control
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
	num_errors++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module adcsq_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import adcsq_pkg::*;
	logic clk_sys_i, rst_b_i, psel_i, penable_i, pwrite_i;
	logic core_halted_i, other_wake_i, irq_ack_i;
	logic [ADDR_W-1:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic pready_o, pslverr_o, irq_req_o, wake_o, er;
	logic [9:0] analog_code_i;
	logic [1:0] ref_sel_o;
	logic [3:0] channel_sel_o;
	logic ext_ref_only_o, channel_valid_o, analog_on_o, sample_o;
	int num_errors = 0, num_checks = 0, now = 0, t0, cyc, f, n;
	adcsq_ctrl dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .core_halted_i(core_halted_i),
		.other_wake_i(other_wake_i), .irq_ack_i(irq_ack_i),
		.irq_req_o(irq_req_o), .wake_o(wake_o), .analog_code_i(analog_code_i),
		.ref_sel_o(ref_sel_o), .ext_ref_only_o(ext_ref_only_o),
		.channel_sel_o(channel_sel_o), .channel_valid_o(channel_valid_o),
		.analog_on_o(analog_on_o), .sample_o(sample_o));
	adcsq_analog_model partner (.clk_i(clk_sys_i), .ref_i(ref_sel_o),
		.chan_i(channel_sel_o), .on_i(analog_on_o), .code_o(analog_code_i));
	initial begin
		clk_sys_i = 0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) now <= now + 1;
	task end_of_test;
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk_sys_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= {24'h0, d};
		@(posedge clk_sys_i);
		penable_i <= 1;
		do begin @(posedge clk_sys_i); k++; end while (pready_o !== 1'b1 && k < 50);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
		if (k >= 50) num_errors++;
	endtask
	task rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
		apb(0, a, 8'h00);
		`CHK(nm, {24'h0, e}, rd)
	endtask
	task wait_cap;
		do @(posedge clk_sys_i); while (sample_o !== 1'b1 && now - t0 < 4000);
		cyc = now - t0;
	endtask
	task conv(input logic [7:0] c);
		apb(1, OFS_CTRL, c);
		t0 = now;
		wait_cap();
	endtask
	task ack;
		irq_ack_i <= 1;
		@(posedge clk_sys_i) irq_ack_i <= 0;
		repeat (2) @(posedge clk_sys_i);
		`CHK("ack", 1'b0, irq_req_o)
	endtask
	initial begin
		#2000000;
		num_errors++;
		end_of_test();
	end
	initial begin
		{rst_b_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		{core_halted_i, other_wake_i, irq_ack_i} = '0;
		repeat (10) @(posedge clk_sys_i);
		rst_b_i <= 1;
		rchk("sel_rst", OFS_SELECT, 8'h00);
		rchk("ctrl_rst", OFS_CTRL, 8'h00);
		apb(0, 12'h014, 8'h00);
		`CHK("unmapped", 33'h100000000, {er, rd})
		apb(1, OFS_SELECT, 8'hFF);
		rchk("sel_bit4", OFS_SELECT, 8'hEF);
		`CHK("ref_int", 2'h3, ref_sel_o)
		`CHK("ch_gnd", 4'hF, channel_sel_o)
		apb(1, OFS_SELECT, 8'h43);
		apb(1, OFS_CTRL, 8'hC8);
		t0 = now;
		rchk("busy", OFS_CTRL, 8'hC8);
		apb(1, OFS_SELECT, 8'h4F);
		`CHK("ch_held", 4'h3, channel_sel_o)
		wait_cap();
		`CHK("first_len", 1'b1, cyc >= 48 && cyc <= 56)
		rchk("res_lo", OFS_RES_LOW, 8'h3A);
		rchk("res_hi", OFS_RES_HIGH, 8'h01);
		rchk("done", OFS_CTRL, 8'h98);
		`CHK("ch_new", 4'hF, channel_sel_o)
		apb(1, OFS_SELECT, 8'h6F);
		rchk("lj_hi", OFS_RES_HIGH, 8'h4E);
		rchk("lj_lo", OFS_RES_LOW, 8'h80);
		apb(1, OFS_SELECT, 8'h09);
		@(posedge clk_sys_i);
		`CHK("ch_none", 1'b0, channel_valid_o)
		`CHK("ext_ref", 1'b1, ext_ref_only_o)
		apb(1, OFS_SELECT, 8'h6F);
		apb(1, OFS_CTRL, 8'h98);
		rchk("clear", OFS_CTRL, 8'h88);
		for (int d = 0; d < 8; d++) begin
			f = (d == 0) ? 2 : (1 << d);
			conv(8'hC8 | 8'(d));
			`CHK("len", 1'b1, cyc >= 13*f-2 && cyc <= 14*f+4)
		end
		rchk("gnd", OFS_RES_HIGH, 8'h00);
		conv(8'hE8);
		t0 = now;
		wait_cap();
		`CHK("free_gap", 13*2, cyc)
		rchk("free_busy", OFS_CTRL, 8'hF8);
		apb(1, OFS_CTRL, 8'h88);
		t0 = now;
		wait_cap();
		rchk("free_stop", OFS_CTRL, 8'h98);
		apb(1, OFS_CTRL, 8'h98);
		apb(1, OFS_SLEEP, 8'h02);
		core_halted_i <= 1;
		t0 = now;
		do @(posedge clk_sys_i); while (wake_o !== 1'b1 && now - t0 < 200);
		`CHK("wake", 1'b1, wake_o)
		@(posedge clk_sys_i);
		`CHK("irq", 1'b1, irq_req_o)
		core_halted_i <= 0;
		ack();
		apb(1, OFS_SLEEP, 8'h01);
		core_halted_i <= 1;
		repeat (3) @(posedge clk_sys_i);
		other_wake_i <= 1;
		core_halted_i <= 0;
		@(posedge clk_sys_i) other_wake_i <= 0;
		t0 = now;
		do @(posedge clk_sys_i); while (irq_req_o !== 1'b1 && now - t0 < 200);
		`CHK("late_irq", 1'b1, irq_req_o)
		ack();
		rchk("slp_clr", OFS_SLEEP, 8'h00);
		apb(1, OFS_SLEEP, 8'h04);
		core_halted_i <= 1;
		repeat (80) @(posedge clk_sys_i);
		`CHK("on_kept", 1'b1, analog_on_o)
		core_halted_i <= 0;
		rchk("no_conv", OFS_CTRL, 8'h88);
		apb(1, OFS_CTRL, 8'h00);
		`CHK("off", 1'b0, analog_on_o)
		end_of_test();
	end
endmodule // adcsq_ctrl_tb_top
bind adcsq_ctrl adcsq_ctrl_asserts u_chk (.clk_sys_i(clk_sys_i),
	.rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .wake_o(wake_o), .irq_req_o(irq_req_o),
	.ref_sel_o(ref_sel_o), .ext_ref_only_o(ext_ref_only_o),
	.channel_sel_o(channel_sel_o), .channel_valid_o(channel_valid_o),
	.analog_on_o(analog_on_o), .sample_o(sample_o));
